/* File: rtl/tdi_defs.svh */
// Register offsets, field positions, reset values and sizes of the descriptor interpreter
`ifndef TDI_DEFS_SVH
`define TDI_DEFS_SVH

`define TDI_OFF_CTRL 8'h00
`define TDI_OFF_TABLE_BASE 8'h04
`define TDI_OFF_STATUS 8'h08
`define TDI_OFF_QSTATE 8'h0C

`define TDI_CTRL_CACHE_EN 0
`define TDI_STATUS_IRQ 0
`define TDI_STATUS_CNT_LSB 1
`define TDI_STATUS_FLUSH 4
`define TDI_TABLE_BASE_LSB 4

`define TDI_CTRL_RESET 32'h0000_0001
`define TDI_TABLE_BASE_RESET 28'h000_0000

`define TDI_CACHE_DEPTH 6
`define TDI_CACHE_FULL 3'h6
`define TDI_CACHE_PUSH_LIMIT 3'h3
`define TDI_DESC_SHIFT 4

`define TDI_ST_LAST_READ 2'h0
`define TDI_ST_PART_READ 2'h1
`define TDI_ST_UNPROV 2'h2

`define TDI_LISTS 128

`endif

/* File: rtl/tdi_pkg.sv */
// Types shared by the transmit descriptor interpreter
package tdi_pkg;

   // Descriptor as read from host memory, fields already unpacked
   typedef struct packed {
      logic [31:0] buf_addr;
      logic [15:0] byte_count;
      logic [15:0] buf_size;
      logic prio_high;
      logic link_valid;
      logic more_frags;
      logic chain_end;
      logic [6:0] channel_code;
      logic [13:0] engine_link;
      logic abort_flag;
      logic completion_irq_request;
      logic [13:0] host_link;
   } tdi_desc_s;

   // Report that a descriptor buffer has been completely read
   typedef struct packed {
      logic [13:0] ref_id;
      logic [6:0] channel_code;
      logic prio_high;
      logic more_frags;
      logic abort_flag;
      logic completion_irq_request;
      logic link_valid;
      logic [13:0] engine_link;
   } tdi_done_s;

   // Write of the engine link field of one descriptor
   typedef struct packed {
      logic en;
      logic [13:0] target_ref;
      logic [13:0] next_ref;
      logic link_valid;
   } tdi_link_wr_s;

   // Free queue element, low 17 bits
   typedef struct packed {
      logic underflow;
      logic [1:0] status;
      logic [13:0] ref_id;
   } tdi_free_s;

   // Whole state of the interpreter
   typedef struct packed {
      logic cache_en;
      logic [27:0] table_base;
      logic irq;
      logic [1:0][127:0] head_v;
      logic [1:0][127:0][13:0] head;
      logic [1:0][127:0][13:0] tail;
      logic [5:0][16:0] cache;
      logic [2:0] cnt;
      logic flushing;
      logic unprov_pend;
      logic [6:0] unprov_chan;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic ret_ready;
      logic free_valid;
      tdi_free_s free_data;
      logic fetch_valid;
      logic [31:0] fetch_addr;
      logic [15:0] fetch_len;
      logic follow_valid;
      logic [31:0] follow_addr;
      logic grant_valid;
      logic grant_high;
      logic pkt_abort;
      tdi_link_wr_s tail_wr;
      tdi_link_wr_s new_wr;
   } tdi_state_s;

endpackage

/* File: rtl/tdi_tx_descriptor_interpreter.sv */
// Transmit descriptor interpreter: decode, per-list linking, free queue cache, APB registers
//
// Summary of operation
// RULE1: Buffer start address sets packet data fetch.
// RULE2: Byte count sets bytes fetched from buffer.
// RULE3: High queue first; low waits until empty.
// RULE4: Engine link valid flag set when link valid.
// RULE5: More-fragments marks non-final piece of packet.
// RULE6: Host never sets more-fragments with chain-end.
// RULE7: Chain-end stops; else follow host link.
// RULE8: Raw data coded as single-packet chain.
// RULE9: One channel code for a whole chain.
// RULE10: Engine links build per-channel per-priority lists.
// RULE11: Unprovisioned channel returns its list head.
// RULE12: Abort after whole buffer has been sent.
// RULE13: Aborting host sets chain-end, clears more-fragments.
// RULE14: Completion request raises interrupt after buffer read.
// RULE15: Completion request flushes the free queue cache.
// RULE16: Host lists: one packet or same channel/priority.
// RULE17: Buffer size field is ignored.
// RULE18: Descriptor address is base plus sixteen times reference.
// RULE19: Cache six references; write six at once.
// RULE20: Unprovisioned return carries status binary 10.
// RULE21: Completion interrupt latched until software clears.
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "tdi_defs.svh"

module tdi_tx_descriptor_interpreter (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic desc_valid,
   input wire logic [13:0] desc_ref,
   input wire tdi_pkg::tdi_desc_s desc,
   output logic fetch_valid,
   output logic [31:0] fetch_addr,
   output logic [15:0] fetch_len,
   output logic follow_valid,
   output logic [31:0] follow_addr,
   output tdi_pkg::tdi_link_wr_s tail_wr,
   output tdi_pkg::tdi_link_wr_s new_wr,
   input wire logic tx_slot,
   output logic grant_valid,
   output logic grant_high,
   input wire logic done_valid,
   input wire tdi_pkg::tdi_done_s done,
   output logic pkt_abort,
   input wire logic unprov_valid,
   input wire logic [6:0] unprov_chan,
   output logic ret_ready,
   output logic free_valid,
   output tdi_pkg::tdi_free_s free_data,
   input wire logic free_ready,
   output logic completion_irq
);

   tdi_pkg::tdi_state_s s_reg;
   tdi_pkg::tdi_state_s s_next;
   logic apb_setup;
   logic apb_write;
   logic hi_any;
   logic lo_any;

   assign apb_setup = psel & ~penable;
   assign apb_write = psel & penable & pwrite & s_reg.pready;
   assign hi_any = |s_reg.head_v[1];
   assign lo_any = |s_reg.head_v[0];

   // Append one entry to the free queue cache
   function automatic tdi_pkg::tdi_state_s push_free(input tdi_pkg::tdi_state_s st,
                                                    input logic [1:0] status,
                                                    input logic [13:0] ref_id);
      tdi_pkg::tdi_state_s r;
      tdi_pkg::tdi_free_s e;
      r = st;
      e.underflow = 1'b0;
      e.status = status;
      e.ref_id = ref_id;
      r.cache[r.cnt] = e;
      r.cnt = r.cnt + 3'h1;
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      logic [6:0] ch;
      logic p;
      logic [31:0] rd;
      ch = 7'h00;
      p = 1'b0;
      rd = 32'h0000_0000;
      s_next = s_reg;

      // Pulses last one cycle
      s_next.fetch_valid = 1'b0;
      s_next.follow_valid = 1'b0;
      s_next.grant_valid = 1'b0;
      s_next.pkt_abort = 1'b0;
      s_next.tail_wr.en = 1'b0;
      s_next.new_wr.en = 1'b0;

      // APB: answer in the access phase right after setup
      s_next.pready = apb_setup;
      s_next.pslverr = 1'b0;
      if (apb_setup) begin
         unique case (paddr)
            `TDI_OFF_CTRL: rd[`TDI_CTRL_CACHE_EN] = s_reg.cache_en;
            `TDI_OFF_TABLE_BASE: rd[31:`TDI_TABLE_BASE_LSB] = s_reg.table_base;
            `TDI_OFF_STATUS: begin
               rd[`TDI_STATUS_IRQ] = s_reg.irq;
               rd[`TDI_STATUS_CNT_LSB +: 3] = s_reg.cnt;
               rd[`TDI_STATUS_FLUSH] = s_reg.flushing;
            end
            `TDI_OFF_QSTATE: rd[1:0] = {lo_any, hi_any};
            default: s_next.pslverr = 1'b1; // Unmapped offset
         endcase
         s_next.prdata = rd;
      end
      if (apb_write) begin
         unique case (paddr)
            `TDI_OFF_CTRL: s_next.cache_en = pwdata[`TDI_CTRL_CACHE_EN];
            `TDI_OFF_TABLE_BASE: s_next.table_base = pwdata[31:`TDI_TABLE_BASE_LSB];
            `TDI_OFF_STATUS: begin
               if (pwdata[`TDI_STATUS_IRQ]) begin
                  s_next.irq = 1'b0; // Write one to clear
               end
            end
            default: ;
         endcase
      end

      // Free queue drain: one element per accepted beat
      if (s_reg.free_valid && free_ready) begin
         for (int i = 0; i < `TDI_CACHE_DEPTH - 1; i++) begin
            s_next.cache[i] = s_reg.cache[i + 1];
         end
         s_next.cnt = s_reg.cnt - 3'h1;
      end

      // Finished buffer: unlink, return reference, abort, interrupt
      if (done_valid) begin
         ch = done.channel_code;
         p = done.prio_high;
         if (done.link_valid) begin // RULE4
            s_next.head[p][ch] = done.engine_link;
         end else begin
            s_next.head_v[p][ch] = 1'b0;
         end
         s_next = push_free(s_next, done.more_frags ? `TDI_ST_PART_READ :
                            `TDI_ST_LAST_READ, done.ref_id); // RULE5
         s_next.pkt_abort = done.abort_flag; // RULE12
         if (done.completion_irq_request) begin
            s_next.irq = 1'b1; // RULE14 RULE21
            s_next.flushing = 1'b1; // RULE15
         end
      end

      // Unprovisioned channel: latch it, then return high head, then low head,
      // one per cycle and only while the cache has room, so it never overflows
      if (s_reg.unprov_pend) begin
         ch = s_reg.unprov_chan;
         if (s_reg.head_v[1][ch]) begin
            if (s_next.cnt != `TDI_CACHE_FULL) begin
               s_next = push_free(s_next, `TDI_ST_UNPROV, s_reg.head[1][ch]); // RULE11 RULE20
               s_next.head_v[1][ch] = 1'b0;
            end
         end else if (s_reg.head_v[0][ch]) begin
            if (s_next.cnt != `TDI_CACHE_FULL) begin
               s_next = push_free(s_next, `TDI_ST_UNPROV, s_reg.head[0][ch]); // RULE20
               s_next.head_v[0][ch] = 1'b0; // RULE11
            end
         end else begin
            s_next.unprov_pend = 1'b0; // Both lists returned
         end
      end else if (unprov_valid) begin
         s_next.unprov_pend = 1'b1;
         s_next.unprov_chan = unprov_chan;
      end

      // New descriptor: fetch buffer, link into its list, follow host chain
      if (desc_valid) begin
         ch = desc.channel_code; // RULE9
         p = desc.prio_high;
         s_next.fetch_valid = 1'b1;
         s_next.fetch_addr = desc.buf_addr; // RULE1
         s_next.fetch_len = desc.byte_count; // RULE2 RULE17
         s_next.new_wr = '{en: 1'b1, target_ref: desc_ref, next_ref: 14'h0000,
                           link_valid: 1'b0}; // RULE4
         if (s_next.head_v[p][ch]) begin
            s_next.tail_wr = '{en: 1'b1, target_ref: s_reg.tail[p][ch],
                               next_ref: desc_ref, link_valid: 1'b1}; // RULE10 RULE4
         end else begin
            s_next.head[p][ch] = desc_ref; // RULE10
            s_next.head_v[p][ch] = 1'b1;
         end
         s_next.tail[p][ch] = desc_ref;
         if (!desc.chain_end) begin
            s_next.follow_valid = 1'b1; // RULE7
            s_next.follow_addr = {s_reg.table_base, 4'h0} +
                                 {14'h0000, desc.host_link, 4'h0}; // RULE18 RULE16
         end
      end

      // Transmit slot: high lists strictly before low lists
      if (tx_slot && (hi_any || lo_any)) begin
         s_next.grant_valid = 1'b1;
         s_next.grant_high = hi_any; // RULE3
      end

      // Flush when six are held, when caching is off, or on request
      if (s_next.cnt == `TDI_CACHE_FULL || (!s_next.cache_en && s_next.cnt != 3'h0)) begin
         s_next.flushing = 1'b1; // RULE19
      end
      if (s_next.cnt == 3'h0) begin
         s_next.flushing = 1'b0;
      end
      s_next.free_valid = s_next.flushing && s_next.cnt != 3'h0;
      s_next.free_data = s_next.cache[0];
      // At most one done push per cycle, so one free slot is enough and the cache
      // can fill to six; unprovisioned heads wait for room on their own
      s_next.ret_ready = s_next.cnt != `TDI_CACHE_FULL && !s_next.unprov_pend; // RULE19
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg <= '0;
         s_reg.cache_en <= 1'(`TDI_CTRL_RESET);
         s_reg.table_base <= `TDI_TABLE_BASE_RESET;
         s_reg.ret_ready <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs straight from the state register
   assign prdata = s_reg.prdata;
   assign pready = s_reg.pready;
   assign pslverr = s_reg.pslverr;
   assign fetch_valid = s_reg.fetch_valid;
   assign fetch_addr = s_reg.fetch_addr;
   assign fetch_len = s_reg.fetch_len;
   assign follow_valid = s_reg.follow_valid;
   assign follow_addr = s_reg.follow_addr;
   assign tail_wr = s_reg.tail_wr;
   assign new_wr = s_reg.new_wr;
   assign grant_valid = s_reg.grant_valid;
   assign grant_high = s_reg.grant_high;
   assign pkt_abort = s_reg.pkt_abort;
   assign ret_ready = s_reg.ret_ready;
   assign free_valid = s_reg.free_valid;
   assign free_data = s_reg.free_data;
   assign completion_irq = s_reg.irq;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   // Properties triggered by inputs look one edge later at the registered outputs they cause
   a_fetch_addr: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
      desc_valid |=> fetch_valid && fetch_addr == $past(desc.buf_addr))
      else $error("fetch address not taken from descriptor");

   a_fetch_len: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
      desc_valid |=> fetch_len == $past(desc.byte_count))
      else $error("fetch length not taken from byte count");

   a_low_waits: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
      tx_slot && hi_any |=> grant_valid && grant_high)
      else $error("low list granted while high list not empty");

   a_low_grant: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
      tx_slot && !hi_any && lo_any |=> grant_valid && !grant_high)
      else $error("low list not granted when high list empty");

   a_grant_idle: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
      tx_slot && !hi_any && !lo_any |=> !grant_valid)
      else $error("grant with no list queued");

   a_tail_link: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
      tail_wr.en |-> tail_wr.link_valid && !new_wr.link_valid)
      else $error("link valid flag wrong");

   a_new_link: assert property (@(posedge pclk) disable iff (!presetn) // RULE10 RULE4
      desc_valid |=> new_wr.en && new_wr.target_ref == $past(desc_ref) &&
      !new_wr.link_valid)
      else $error("new descriptor link not cleared");

   a_tail_order: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
      desc_valid && !done_valid && !s_reg.unprov_pend &&
      s_reg.head_v[desc.prio_high][desc.channel_code] |=> tail_wr.en &&
      tail_wr.next_ref == $past(desc_ref) &&
      tail_wr.target_ref == $past(s_reg.tail[desc.prio_high][desc.channel_code]))
      else $error("list tail not linked to new descriptor");

   a_follow_chain: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
      desc_valid |=> follow_valid == !$past(desc.chain_end))
      else $error("host chain not followed");

   a_desc_addr: assert property (@(posedge pclk) disable iff (!presetn) // RULE18
      desc_valid && !desc.chain_end |=> follow_addr ==
      {$past(s_reg.table_base), 4'h0} + {14'h0000, $past(desc.host_link), 4'h0})
      else $error("descriptor address miscomputed");

   a_done_entry: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
      done_valid && !s_reg.unprov_pend && !(free_valid && free_ready) |=>
      s_reg.cache[$past(s_reg.cnt)] == {2'b00, $past(done.more_frags), $past(done.ref_id)})
      else $error("returned reference or status wrong");

   a_abort_after: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
      done_valid && done.abort_flag |=> pkt_abort ##1
      (!pkt_abort || $past(done_valid && done.abort_flag)))
      else $error("abort not issued after buffer read");

   a_irq_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE14 RULE21
      done_valid && done.completion_irq_request |=> completion_irq [*2])
      else $error("completion interrupt not latched");

   a_no_irq: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
      done_valid && !done.completion_irq_request && !completion_irq |=> !completion_irq)
      else $error("interrupt raised without request");

   a_cache_bound: assert property (@(posedge pclk) disable iff (!presetn) // RULE19
      s_reg.cnt <= `TDI_CACHE_FULL)
      else $error("free cache overflow");

   a_six_group: assert property (@(posedge pclk) disable iff (!presetn) // RULE19
      $rose(s_reg.flushing) && s_reg.cache_en && $past(s_reg.cache_en) &&
      !$past(done_valid && done.completion_irq_request) |-> s_reg.cnt == `TDI_CACHE_FULL)
      else $error("cache flushed before six were held");

   a_flush_ioc: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
      done_valid && done.completion_irq_request |=> s_reg.flushing && free_valid)
      else $error("cache not flushed on completion request");

   a_unprov_take: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
      unprov_valid && !s_reg.unprov_pend |=> s_reg.unprov_pend &&
      s_reg.unprov_chan == $past(unprov_chan))
      else $error("unprovisioned channel not latched");

endmodule // tdi_tx_descriptor_interpreter

/* File: testbench/tdi_host_model.sv */
// Host side free queue sink that collects returned references
`timescale 1ns/1ps
module tdi_host_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic free_valid,
   input wire tdi_pkg::tdi_free_s free_data,
   input wire logic slow,
   output logic free_ready
);
   tdi_pkg::tdi_free_s got[$];
   logic [1:0] cnt;
   ////////////////////////////////////////////////////////////////////////////
   // Accept beats; slow mode stalls three cycles of four to stress the drain
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 2'h0;
         free_ready <= 1'b0;
      end else begin
         if (free_valid && free_ready)
            got.push_back(free_data);
         cnt <= cnt + 2'h1;
         free_ready <= !slow || cnt == 2'h3;
      end
   end
endmodule // tdi_host_model

/* File: testbench/tdi_tx_descriptor_interpreter_tb.sv */
// Self-checking bench for the transmit descriptor interpreter
`timescale 1ns/1ps
module tdi_tx_descriptor_interpreter_tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, fetch_addr, follow_addr, base, rd;
   logic desc_valid = 0, tx_slot = 0, done_valid = 0, unprov_valid = 0, slow = 0, e;
   logic [13:0] desc_ref = 14'h0;
   logic [6:0] unprov_chan = 7'h00;
   logic [15:0] fetch_len;
   logic fetch_valid, follow_valid, grant_valid, grant_high, pkt_abort, ret_ready;
   logic free_valid, free_ready, completion_irq;
   tdi_pkg::tdi_desc_s desc = '0;
   tdi_pkg::tdi_done_s done = '0;
   tdi_pkg::tdi_link_wr_s tail_wr, new_wr;
   tdi_pkg::tdi_free_s free_data;
   integer errors = 0, check_count = 0, seed = 32'hdd81, i;
   integer lists[256][$];
   logic [16:0] exp_q[$];

   always #5 pclk = ~pclk;

   tdi_tx_descriptor_interpreter dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .desc_valid(desc_valid), .desc_ref(desc_ref),
      .desc(desc), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .fetch_len(fetch_len),
      .follow_valid(follow_valid), .follow_addr(follow_addr), .tail_wr(tail_wr),
      .new_wr(new_wr), .tx_slot(tx_slot), .grant_valid(grant_valid), .grant_high(grant_high),
      .done_valid(done_valid), .done(done), .pkt_abort(pkt_abort),
      .unprov_valid(unprov_valid), .unprov_chan(unprov_chan), .ret_ready(ret_ready),
      .free_valid(free_valid), .free_data(free_data), .free_ready(free_ready),
      .completion_irq(completion_irq));
   tdi_host_model host (.pclk(pclk), .presetn(presetn), .free_valid(free_valid),
      .free_data(free_data), .slow(slow), .free_ready(free_ready));

   ////////////////////////////////////////////////////////////////////////////
   // Verdict, comparison and bounded wait helpers
   task give_verdict;
      if (errors == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task timeout(input integer n);
      if (n >= 200) begin
         chk(32'h0, 32'h1);
         give_verdict();
      end
   endtask
   // APB master: hold the request until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      integer n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 200);
      timeout(n);
      rd = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Offer one descriptor and check decode, linking and the follow address
   task send(input logic [13:0] r, input logic [6:0] ch, input logic pr, input logic ce);
      tdi_pkg::tdi_desc_s d;
      d = '0;
      d.buf_addr = $random(seed);
      d.byte_count = $random(seed);
      d.buf_size = $random(seed);
      d.prio_high = pr;
      d.more_frags = !ce;
      d.chain_end = ce;
      d.channel_code = ch;
      d.host_link = $random(seed);
      desc_valid <= 1'b1;
      desc_ref <= r;
      desc <= d;
      @(posedge pclk);
      desc_valid <= 1'b0;
      #1;
      chk(fetch_valid, 1);
      chk(fetch_addr, d.buf_addr);
      chk(fetch_len, d.byte_count);
      chk(new_wr, {1'b1, r, 14'h0, 1'b0});
      chk(follow_valid, !ce);
      if (!ce)
         chk(follow_addr, base + {d.host_link, 4'h0});
      if (lists[{ch, pr}].size() > 0)
         chk(tail_wr, {1'b1, 14'(lists[{ch, pr}][$]), r, 1'b1});
      else
         chk(tail_wr.en, 0);
      lists[{ch, pr}].push_back(r);
      @(posedge pclk);
   endtask
   // Report a read buffer; model the returned reference and list head
   task retire(input logic [13:0] r, input logic [6:0] ch, input logic pr, input logic m,
               input logic ab, input logic ic);
      integer n;
      n = 0;
      while (ret_ready !== 1'b1 && n < 200) begin
         @(posedge pclk);
         n++;
      end
      timeout(n);
      if (lists[{ch, pr}].size() > 0)
         void'(lists[{ch, pr}].pop_front());
      done_valid <= 1'b1;
      done <= '{ref_id: r, channel_code: ch, prio_high: pr, more_frags: m, abort_flag: ab,
               completion_irq_request: ic, link_valid: lists[{ch, pr}].size() > 0,
               engine_link: lists[{ch, pr}].size() > 0 ? 14'(lists[{ch, pr}][0]) : 14'h0};
      @(posedge pclk);
      done_valid <= 1'b0;
      #1;
      chk(pkt_abort, ab);
      chk(completion_irq, ic);
      exp_q.push_back({1'b0, 1'b0, m, r});
      @(posedge pclk);
   endtask
   task tx(input logic h);
      tx_slot <= 1'b1;
      @(posedge pclk);
      tx_slot <= 1'b0;
      #1;
      chk(grant_valid, 1);
      chk(grant_high, h);
      @(posedge pclk);
   endtask
   // Wait for the host to hold every expected reference, then compare in order
   task expect_free;
      integer n;
      n = 0;
      while (host.got.size() < exp_q.size() && n < 200) begin
         @(posedge pclk);
         n++;
      end
      timeout(n);
      while (exp_q.size() > 0)
         chk(host.got.pop_front(), exp_q.pop_front());
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (6) @(posedge pclk);
      chk(ret_ready, 1);
      presetn <= 1'b1;
      @(posedge pclk);
      for (i = 0; i < 4; i++) begin
         apb(0, 8'(i * 4), 0);
         chk(rd, i == 0);
      end
      apb(0, 8'h10, 0);
      chk(e, 1);
      chk(rd, 0);
      base = $random(seed) & 32'hFFFF_FFF0;
      apb(1, 8'h04, base);
      apb(0, 8'h04, 0);
      chk(rd, base);
      send(14'h0011, 7'h05, 1, 0);
      send(14'h0012, 7'h05, 1, 1);
      send(14'h0013, 7'h05, 0, 1);
      apb(0, 8'h0C, 0);
      chk(rd, 32'h3);
      tx(1);
      retire(14'h0011, 7'h05, 1, 1, 0, 0);
      retire(14'h0012, 7'h05, 1, 0, 1, 0);
      chk(free_valid, 0);
      tx(0);
      slow <= 1'b1;
      retire(14'h0013, 7'h05, 0, 0, 0, 1);
      expect_free();
      repeat (5) @(posedge pclk);
      apb(0, 8'h08, 0);
      chk(rd[4:0], 5'h01);
      apb(1, 8'h08, 32'h1);
      apb(0, 8'h08, 0);
      chk(rd[0] | completion_irq, 0);
      apb(1, 8'h00, 0);
      send(14'h0020, 7'h09, 1, 1);
      send(14'h0021, 7'h09, 0, 1);
      unprov_valid <= 1'b1;
      unprov_chan <= 7'h09;
      @(posedge pclk);
      unprov_valid <= 1'b0;
      exp_q.push_back({1'b0, 2'h2, 14'h0020});
      exp_q.push_back({1'b0, 2'h2, 14'h0021});
      lists[{7'h09, 1'b1}].delete();
      lists[{7'h09, 1'b0}].delete();
      @(posedge pclk);
      expect_free();
      apb(1, 8'h00, 32'h1);
      // Caching on: nothing leaves until the sixth reference is held
      for (i = 0; i < 6; i++) begin
         retire(14'($random(seed)), 7'h64, 1'($random(seed)), 1'($random(seed)), 0, 0);
         chk(free_valid, i == 5);
      end
      expect_free();
      chk(host.got.size(), 0);
      give_verdict();
   end
endmodule // tdi_tx_descriptor_interpreter_tb
